// ---- dv/crp_operator.sv ----
// operator model: presses panel and channel buttons as one-cycle pulses
// assumes the bench calls press() and then waits on the controller itself
`timescale 1ns/10ps
`default_nettype none
module crp_operator (
  input wire logic core_clk_in,
  output logic sel_press_out,
  output logic [4:0] sel_chan_out,
  output logic plus_out,
  output logic minus_out,
  output logic range_btn_out,
  output logic scatter_btn_out,
  output logic all_btn_out,
  output logic func_press_out,
  output logic [4:0] func_idx_out,
  output logic set_btn_out,
  output logic clear_btn_out,
  output logic undo_btn_out
);
  // ==========
  // button drive
  logic [10:0] b = 11'h000;
  logic [4:0] v = 5'h00;
  assign sel_press_out = b[0];
  assign sel_chan_out = v;
  assign plus_out = b[1] | b[3];
  assign minus_out = b[2] | b[3];
  assign range_btn_out = b[4];
  assign scatter_btn_out = b[5];
  assign all_btn_out = b[6];
  assign func_press_out = b[7];
  assign func_idx_out = v;
  assign set_btn_out = b[8];
  assign clear_btn_out = b[9];
  assign undo_btn_out = b[10];
  // inverted after release so the idle channel value never equals the one just pressed
  task automatic press(input int k, input logic [4:0] x);
    @(posedge core_clk_in);
    #1;
    b = 11'h001 << k;
    v = x;
    @(posedge core_clk_in);
    #1;
    b = 11'h000;
    v = ~x;
  endtask : press
endmodule : crp_operator
`default_nettype wire

// ---- dv/crp_panel_monitor.sv ----
// assertion monitor bound onto the routing panel controller
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module crp_panel_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic sel_press_in,
  input wire logic [4:0] sel_chan_in,
  input wire logic plus_in,
  input wire logic minus_in,
  input wire logic range_btn_in,
  input wire logic after_fader_listen_in,
  input wire logic exempt_afl_solo_opt_in,
  input wire logic [23:0] solo_req_in,
  input wire logic panel_active_out,
  input wire logic busy_out,
  input wire logic [4:0] from_chan_out,
  input wire logic from_shown_out,
  input wire logic [4:0] to_chan_out,
  input wire logic to_shown_out,
  input wire logic [23:0] sel_mask_out,
  input wire logic [767:0] chan_state_out,
  input wire logic [23:0] mute_out,
  input wire logic [23:0] auto_solo_out
);
  // ==========
  // checks
  // ch5 and ch1 are the probe channels; a loop over all would cost more than it buys
  logic mc;
  logic ac;
  assign mc = |solo_req_in && !solo_req_in[1] && !chan_state_out[61];
  assign ac = after_fader_listen_in && exempt_afl_solo_opt_in && chan_state_out[189] && |solo_req_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  AST_WAKE: assert property (!panel_active_out && !busy_out && sel_press_in |=>
    panel_active_out && sel_mask_out == 24'h000001 << $past(sel_chan_in)) else $error("wake selection wrong");
  AST_BLANK: assert property ($fell(panel_active_out) |-> ##[0:2] !from_shown_out && !to_shown_out)
    else $error("windows lit while panel off");
  AST_SINGLE: assert property ($rose(panel_active_out) |=> from_shown_out && !to_shown_out)
    else $error("single selection display wrong");
  AST_PM_OFF: assert property (panel_active_out && !busy_out && plus_in && minus_in && !sel_press_in
    |=> !panel_active_out) else $error("plus and minus did not switch off");
  AST_RANGE: assert property (panel_active_out && !busy_out && range_btn_in && !to_shown_out && !sel_press_in
    && !plus_in && !minus_in && from_chan_out < 5'h17 |-> ##[1:2] to_shown_out
    && to_chan_out == from_chan_out + 5'h01) else $error("range end not next channel");
  AST_SWAP: assert property ($rose(chan_state_out[188]) && !busy_out |-> !chan_state_out[187])
    else $error("phantom left on after swap");
  AST_EXEMPT: assert property (chan_state_out[189] && $past(chan_state_out[189]) |-> !mute_out[5])
    else $error("exempt channel muted");
  AST_MUTE: assert property (!$past(rst_in) && $past(mc) |-> ##[0:1] mute_out[1])
    else $error("unsoloed channel not muted");
  AST_AUTO: assert property (!$past(rst_in) && $past(ac) |-> ##[0:1] auto_solo_out[5])
    else $error("exempt channel not auto soloed");
endmodule : crp_panel_monitor
bind crp_routing_panel crp_panel_monitor i_mon (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .sel_press_in(sel_press_in), .sel_chan_in(sel_chan_in), .plus_in(plus_in), .minus_in(minus_in),
  .range_btn_in(range_btn_in), .after_fader_listen_in(after_fader_listen_in),
  .exempt_afl_solo_opt_in(exempt_afl_solo_opt_in), .solo_req_in(solo_req_in),
  .panel_active_out(panel_active_out), .busy_out(busy_out), .from_chan_out(from_chan_out),
  .from_shown_out(from_shown_out), .to_chan_out(to_chan_out), .to_shown_out(to_shown_out),
  .sel_mask_out(sel_mask_out), .chan_state_out(chan_state_out), .mute_out(mute_out),
  .auto_solo_out(auto_solo_out));
`default_nettype wire

// ---- dv/crp_routing_panel_tb.sv ----
// self-checking bench for the routing panel controller
// assumes crp_operator as button pusher and the bound monitor
`timescale 1ns/10ps
`default_nettype none
module crp_routing_panel_tb;
  // ==========
  // bench state
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] lv = 8'h00;
  logic [23:0] solo = 24'h000000;
  int n_fail = 0;
  int n_compared = 0;
  logic sp, pl, mi, rb, sb, ab, fp, stb, clb, ub, act, busy, fs, ts, scl, stl, cll, mv;
  logic [4:0] sc, fi, fc, tc, pb, mc;
  logic [23:0] sm, mu, as, fx;
  logic [767:0] cs;
  always #5 clk = ~clk;
  crp_operator i_op (.core_clk_in(clk), .sel_press_out(sp), .sel_chan_out(sc), .plus_out(pl), .minus_out(mi),
    .range_btn_out(rb), .scatter_btn_out(sb), .all_btn_out(ab), .func_press_out(fp), .func_idx_out(fi),
    .set_btn_out(stb), .clear_btn_out(clb), .undo_btn_out(ub));
  // short undo window and flash period keep the run brief
  crp_routing_panel #(.UNDO_CYC(20), .FLASH_CYC(4)) i_dut (.core_clk_in(clk), .rst_in(rst),
    .sel_press_in(sp), .sel_chan_in(sc), .plus_in(pl), .minus_in(mi), .range_btn_in(rb),
    .scatter_btn_in(sb), .all_btn_in(ab), .func_press_in(fp), .func_idx_in(fi), .set_btn_in(stb),
    .clear_btn_in(clb), .undo_btn_in(ub), .inc_route_in(lv[0]), .aux_copy_in(lv[1]),
    .pan_to_track_busses_in(lv[2]), .surround_pan_in(lv[3]), .effects_send_to_tracks_in(lv[4]),
    .master_fader_channel_assign_in(lv[5]), .after_fader_listen_in(lv[6]),
    .exempt_afl_solo_opt_in(lv[7]), .solo_req_in(solo), .panel_active_out(act), .busy_out(busy),
    .from_chan_out(fc), .from_shown_out(fs), .to_chan_out(tc), .to_shown_out(ts),
    .scatter_lamp_out(scl), .set_lamp_out(stl), .clear_lamp_out(cll), .sel_mask_out(sm),
    .chan_state_out(cs), .mute_out(mu), .auto_solo_out(as), .fx_to_track_out(fx),
    .pan_base_out(pb), .mf_chan_out(mc), .mf_valid_out(mv));
  // ==========
  // helpers
  function automatic logic st(input int c, input int b);
    return cs[c*32+b];
  endfunction : st
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // waits out any snapshot or restore sweep, bounded
  task automatic go(input int k, input logic [4:0] x);
    int n;
    n = 0;
    i_op.press(k, x);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (n < 80 && (n < 4 || busy !== 1'b0));
    if (busy !== 1'b0) n_fail++;
  endtask : go
  task automatic blink(input int w);
    int h;
    h = 0;
    repeat (10) begin
      @(posedge clk);
      #1;
      if ((w ? stl : scl) === 1'b1) h++;
    end
    chk(h != 0 && h != 10, 1'h1);
  endtask : blink
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // ==========
  // scenarios
  task automatic t_wake();
    go(0, 5'h06);
    chk({act, fc, fs, ts}, 8'h9a);
    chk(sm, 24'h000040);
    go(7, 5'h03);
    go(0, 5'h05);
    chk({fc, sm}, 29'h05000020);
  endtask : t_wake
  task automatic t_range();
    go(4, 5'h00);
    chk({ts, tc, sm}, 30'h26000060);
    go(7, 5'h03);
    chk({st(5, 3), st(6, 3)}, 2'h3);
    go(7, 5'h03);
    chk({st(5, 3), st(6, 3)}, 2'h0);
    lv = 8'h01;
    go(7, 5'h03);
    chk({st(5, 3), st(6, 4)}, 2'h3);
  endtask : t_range
  task automatic t_swap_solo();
    go(7, 5'h1b);
    go(7, 5'h1c);
    chk({st(5, 28), st(5, 27), st(6, 27)}, 3'h4);
    go(7, 5'h1d);
    go(7, 5'h1f);
    lv = 8'hf4;
    solo = 24'h000001;
    repeat (4) @(posedge clk);
    #1;
    chk({mu[5], mu[1], as[5]}, 3'h3);
    chk({mv, mc, pb, fx[6:5]}, 13'h1289);
    lv = 8'h00;
    solo = 24'h000000;
  endtask : t_swap_solo
  task automatic t_off();
    go(3, 5'h00);
    chk(act, 1'h0);
    go(3, 5'h00);
    chk({act, fc}, 6'h25);
    go(0, 5'h05);
    chk(act, 1'h0);
  endtask : t_off
  task automatic t_undo();
    go(0, 5'h09);
    go(7, 5'h0c);
    go(10, 5'h00);
    repeat (30) @(posedge clk);
    go(10, 5'h00);
    repeat (30) @(posedge clk);
    chk({act, st(9, 12)}, 2'h3);
    i_op.press(10, 5'h00);
    go(10, 5'h00);
    chk({act, st(9, 12)}, 2'h0);
  endtask : t_undo
  task automatic t_scatter();
    go(0, 5'h09);
    go(5, 5'h00);
    blink(0);
    go(0, 5'h02);
    chk(sm, 24'h000204);
    go(6, 5'h00);
    chk(sm, 24'hffffff);
    go(5, 5'h00);
  endtask : t_scatter
  task automatic t_setclr();
    logic acc;
    acc = 1'b1;
    go(8, 5'h00);
    chk(stl, 1'h1);
    go(7, 5'h0a);
    i_op.press(6, 5'h00);
    blink(1);
    go(8, 5'h00);
    for (int c = 0; c < 24; c++) acc = acc & st(c, 10);
    chk(acc, 1'h1);
    go(9, 5'h00);
    chk(cll, 1'h1);
    go(7, 5'h0a);
    go(0, 5'h02);
    chk({st(2, 10), st(3, 10)}, 2'h1);
  endtask : t_setclr
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    t_wake();
    t_range();
    t_swap_solo();
    t_off();
    t_undo();
    t_scatter();
    t_setclr();
    end_of_test();
  end
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule : crp_routing_panel_tb
`default_nettype wire

// ---- hw/crp_pkg.sv ----
// constants, state codes and timing for the channel routing panel controller
// assumes a single 100 MHz clock and operator buttons already debounced into one-cycle pulses
package crp_pkg;
  localparam int NUM_CH = 24;
  localparam int CH_W = 5;
  localparam int NUM_TRK = 24;
  localparam int FN_W = 32;
  localparam int FN_IDX_W = 5;
  // per-channel word layout: bits 0..23 track busses, then mix and setup bits
  localparam int FN_MIX_A = 24;
  localparam int FN_MIX_B = 25;
  localparam int FN_MIX_C = 26;
  localparam int FN_PHANTOM = 27;
  localparam int FN_IN_SWAP = 28;
  localparam int FN_SOLO_EX = 29;
  localparam int FN_CUE_ON = 30;
  localparam int FN_FX_ON = 31;
  localparam logic [FN_W-1:0] CHAN_RST = 32'h0000_0000;
  localparam logic [CH_W-1:0] LAST_CH = 5'h17;
  localparam logic [CH_W-1:0] STEREO_MASK = 5'h1e;
  localparam logic [CH_W-1:0] SURR_GROUP = 5'h06;
  localparam logic [1:0] ARM_NONE = 2'h0;
  localparam logic [1:0] ARM_SET = 2'h1;
  localparam logic [1:0] ARM_CLR = 2'h2;
  localparam longint CLK_HZ = 100_000_000;
  localparam longint UNDO_WINDOW_MS = 500;
  localparam longint FLASH_HALF_MS = 250;
  localparam int UNDO_CYC = int'(UNDO_WINDOW_MS * CLK_HZ / 1000);
  localparam int FLASH_CYC = int'(FLASH_HALF_MS * CLK_HZ / 1000);
  localparam int CNT_W = 26;
  typedef enum logic [1:0] {
    CRP_IDLE = 2'b00,
    CRP_SNAP = 2'b01,
    CRP_RESTORE = 2'b10
  } crp_seq_t;
endpackage : crp_pkg

// ---- hw/crp_routing_panel.sv ----
// central routing panel controller: selection, routing changes, set/clear, undo
// assumes buttons arrive as synchronous one-cycle pulses; plus and minus together means both high in one cycle
`timescale 1ns/10ps
`default_nettype none
module crp_routing_panel #(
  parameter int UNDO_CYC = crp_pkg::UNDO_CYC,
  parameter int FLASH_CYC = crp_pkg::FLASH_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic sel_press_in,
  input wire logic [crp_pkg::CH_W-1:0] sel_chan_in,
  input wire logic plus_in,
  input wire logic minus_in,
  input wire logic range_btn_in,
  input wire logic scatter_btn_in,
  input wire logic all_btn_in,
  input wire logic func_press_in,
  input wire logic [crp_pkg::FN_IDX_W-1:0] func_idx_in,
  input wire logic set_btn_in,
  input wire logic clear_btn_in,
  input wire logic undo_btn_in,
  input wire logic inc_route_in,
  input wire logic aux_copy_in,
  input wire logic pan_to_track_busses_in,
  input wire logic surround_pan_in,
  input wire logic effects_send_to_tracks_in,
  input wire logic master_fader_channel_assign_in,
  input wire logic after_fader_listen_in,
  input wire logic exempt_afl_solo_opt_in,
  input wire logic [crp_pkg::NUM_CH-1:0] solo_req_in,
  output logic panel_active_out,
  output logic busy_out,
  output logic [crp_pkg::CH_W-1:0] from_chan_out,
  output logic from_shown_out,
  output logic [crp_pkg::CH_W-1:0] to_chan_out,
  output logic to_shown_out,
  output logic scatter_lamp_out,
  output logic set_lamp_out,
  output logic clear_lamp_out,
  output logic [crp_pkg::NUM_CH-1:0] sel_mask_out,
  output logic [crp_pkg::NUM_CH*crp_pkg::FN_W-1:0] chan_state_out,
  output logic [crp_pkg::NUM_CH-1:0] mute_out,
  output logic [crp_pkg::NUM_CH-1:0] auto_solo_out,
  output logic [crp_pkg::NUM_CH-1:0] fx_to_track_out,
  output logic [crp_pkg::CH_W-1:0] pan_base_out,
  output logic [crp_pkg::CH_W-1:0] mf_chan_out,
  output logic mf_valid_out
);
  localparam int N = crp_pkg::NUM_CH;
  localparam int W = crp_pkg::FN_W;

  // =========================================================
  // helper functions
  // =========================================================
  function automatic logic [crp_pkg::CH_W-1:0] first_set(input logic [N-1:0] m);
    logic [crp_pkg::CH_W-1:0] r;
    r = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (m[k]) begin
        r = crp_pkg::CH_W'(k);
      end
    end
    return r;
  endfunction : first_set

  function automatic logic [N-1:0] span(input logic [crp_pkg::CH_W-1:0] lo, input logic [crp_pkg::CH_W-1:0] hi);
    logic [N-1:0] r;
    r = '0;
    for (int k = 0; k < N; k++) begin
      r[k] = (crp_pkg::CH_W'(k) >= lo) && (crp_pkg::CH_W'(k) <= hi);
    end
    return r;
  endfunction : span

  // a word with the swap bit newly on loses phantom power
  function automatic logic [W-1:0] swap_guard(input logic [W-1:0] old_w, input logic [W-1:0] new_w);
    logic [W-1:0] r;
    r = new_w;
    if (new_w[crp_pkg::FN_IN_SWAP] && !old_w[crp_pkg::FN_IN_SWAP]) begin
      r[crp_pkg::FN_PHANTOM] = 1'b0;
    end
    return r;
  endfunction : swap_guard

  // =========================================================
  // state
  // =========================================================
  crp_pkg::crp_seq_t seq;
  logic [crp_pkg::CH_W-1:0] seq_idx;
  logic rd_valid;
  logic [crp_pkg::CH_W-1:0] rd_ch;
  logic range_mode;
  logic scatter_mode;
  logic [1:0] arm;
  logic arm_all;
  logic [W-1:0] arm_funcs;
  logic undo_pend;
  logic [crp_pkg::CNT_W-1:0] undo_cnt;
  logic [crp_pkg::CNT_W-1:0] flash_cnt;
  logic flash_ph;
  logic [W-1:0] snap_rd;
  logic [W-1:0] next_word [N];

  logic idle;
  logic pm_both;
  logic wake;
  logic armed;
  logic sc_chan;
  logic sc_all;
  logic func_ev;
  logic undo_go;
  logic restore_done;
  logic [crp_pkg::CH_W-1:0] lead;
  logic [W-1:0] lead_word;
  logic aux_fn;

  assign idle = (seq == crp_pkg::CRP_IDLE);
  assign pm_both = plus_in && minus_in;
  assign wake = !panel_active_out && idle && (sel_press_in || pm_both);
  assign armed = (arm != crp_pkg::ARM_NONE);
  assign sc_chan = panel_active_out && idle && armed && !arm_all && sel_press_in && (arm_funcs != '0);
  // repress same button applies to all
  assign sc_all = panel_active_out && idle && arm_all &&
                  ((arm == crp_pkg::ARM_SET && set_btn_in) || (arm == crp_pkg::ARM_CLR && clear_btn_in));
  assign func_ev = panel_active_out && idle && func_press_in && !armed;
  assign undo_go = panel_active_out && idle && undo_btn_in && undo_pend;
  assign restore_done = (seq == crp_pkg::CRP_RESTORE) && rd_valid && (rd_ch == crp_pkg::LAST_CH);
  assign lead = first_set(sel_mask_out);
  assign lead_word = chan_state_out[lead*W +: W];
  assign aux_fn = (func_idx_in == crp_pkg::FN_IDX_W'(crp_pkg::FN_CUE_ON)) ||
                  (func_idx_in == crp_pkg::FN_IDX_W'(crp_pkg::FN_FX_ON));

  // =========================================================
  // channel state update
  // =========================================================
  always_comb begin
    logic [crp_pkg::CH_W-1:0] rank;
    logic [crp_pkg::CH_W-1:0] tgt;
    logic [W-1:0] w;
    logic [W-1:0] nw;
    logic newval;
    logic hit;
    rank = '0;
    tgt = '0;
    w = '0;
    nw = '0;
    hit = 1'b0;
    // lowest selected channel decides the new value
    newval = !lead_word[func_idx_in];
    for (int i = 0; i < N; i++) begin
      w = chan_state_out[i*W +: W];
      nw = w;
      if (func_ev && sel_mask_out[i]) begin
        if (inc_route_in && (func_idx_in < crp_pkg::FN_IDX_W'(crp_pkg::NUM_TRK))) begin
          // consecutive busses, toggle routes already present
          tgt = func_idx_in + rank;
          if (tgt < crp_pkg::FN_IDX_W'(crp_pkg::NUM_TRK)) begin
            nw[tgt] = !w[tgt];
          end
        end else begin
          // aux changes copy only when aux copy is on
          hit = !aux_fn || aux_copy_in || (crp_pkg::CH_W'(i) == lead);
          if (hit) begin
            nw[func_idx_in] = newval;
          end
        end
        rank = rank + 5'h01;
      end
      if (sc_all || (sc_chan && sel_chan_in == crp_pkg::CH_W'(i))) begin
        nw = (arm == crp_pkg::ARM_SET) ? (w | arm_funcs) : (w & ~arm_funcs);
      end
      nw = swap_guard(w, nw);
      if (seq == crp_pkg::CRP_RESTORE && rd_valid && rd_ch == crp_pkg::CH_W'(i)) begin
        nw = snap_rd;
      end
      next_word[i] = nw;
    end
  end

  generate
    for (genvar g = 0; g < N; g++) begin : g_chan
      // routing bits drive the channel displays
      always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
          chan_state_out[g*W +: W] <= crp_pkg::CHAN_RST;
        end else begin
          chan_state_out[g*W +: W] <= next_word[g];
        end
      end
    end
  endgenerate

  // =========================================================
  // snapshot and restore sequencer
  // =========================================================
  // changes are held off while busy so the snapshot stays a true image of wake time
  crp_snap_mem #(
    .W(W),
    .D(N),
    .AW(crp_pkg::CH_W)
  ) u_snap (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_en_in(seq == crp_pkg::CRP_SNAP),
    .wr_addr_in(seq_idx),
    .wr_data_in(chan_state_out[seq_idx*W +: W]),
    .rd_addr_in(seq_idx),
    .rd_data_out(snap_rd)
  );

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      seq <= crp_pkg::CRP_IDLE;
      seq_idx <= '0;
      rd_valid <= 1'b0;
      rd_ch <= '0;
    end else begin
      rd_valid <= (seq == crp_pkg::CRP_RESTORE) && !restore_done && (rd_ch != crp_pkg::LAST_CH || !rd_valid);
      rd_ch <= seq_idx;
      case (seq)
        crp_pkg::CRP_IDLE: begin
          seq_idx <= '0;
          if (wake) begin
            seq <= crp_pkg::CRP_SNAP;
          end else if (undo_go) begin
            seq <= crp_pkg::CRP_RESTORE;
          end
        end
        crp_pkg::CRP_SNAP: begin
          if (seq_idx == crp_pkg::LAST_CH) begin
            seq <= crp_pkg::CRP_IDLE;
            seq_idx <= '0;
          end else begin
            seq_idx <= seq_idx + 5'h01;
          end
        end
        crp_pkg::CRP_RESTORE: begin
          if (restore_done) begin
            seq <= crp_pkg::CRP_IDLE;
            seq_idx <= '0;
          end else if (seq_idx != crp_pkg::LAST_CH) begin
            seq_idx <= seq_idx + 5'h01;
          end
        end
        default: begin
          seq <= crp_pkg::CRP_IDLE;
        end
      endcase
    end
  end

  // =========================================================
  // selection
  // =========================================================
  // mask lights outline
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      panel_active_out <= 1'b0;
      from_chan_out <= '0;
      to_chan_out <= '0;
      range_mode <= 1'b0;
      scatter_mode <= 1'b0;
      sel_mask_out <= '0;
    end else if (wake) begin
      // pressed channel, or the from channel kept from the old selection
      panel_active_out <= 1'b1;
      range_mode <= 1'b0;
      scatter_mode <= 1'b0;
      if (sel_press_in) begin
        from_chan_out <= sel_chan_in;
        sel_mask_out <= span(sel_chan_in, sel_chan_in);
      end else begin
        sel_mask_out <= span(from_chan_out, from_chan_out);
      end
    end else if (restore_done || (panel_active_out && idle && pm_both)) begin
      // plus-minus together; undo also closes the panel
      panel_active_out <= 1'b0;
      range_mode <= 1'b0;
      scatter_mode <= 1'b0;
      sel_mask_out <= '0;
    end else if (panel_active_out && idle) begin
      if (sel_press_in && !armed) begin
        if (scatter_mode) begin
          sel_mask_out[sel_chan_in] <= !sel_mask_out[sel_chan_in];
        end else if (range_mode) begin
          if (sel_chan_in > from_chan_out) begin
            to_chan_out <= sel_chan_in;
            sel_mask_out <= span(from_chan_out, sel_chan_in);
          end
        end else if (sel_chan_in == from_chan_out) begin
          // reselect closes only in plain mode
          panel_active_out <= 1'b0;
          sel_mask_out <= '0;
        end else begin
          from_chan_out <= sel_chan_in;
          sel_mask_out <= span(sel_chan_in, sel_chan_in);
        end
      end else if ((plus_in ^ minus_in) && !scatter_mode) begin
        if (range_mode) begin
          if (plus_in && to_chan_out != crp_pkg::LAST_CH) begin
            to_chan_out <= to_chan_out + 5'h01;
            sel_mask_out <= span(from_chan_out, to_chan_out + 5'h01);
          end else if (minus_in && to_chan_out > from_chan_out + 5'h01) begin
            to_chan_out <= to_chan_out - 5'h01;
            sel_mask_out <= span(from_chan_out, to_chan_out - 5'h01);
          end
        end else if (plus_in && from_chan_out != crp_pkg::LAST_CH) begin
          from_chan_out <= from_chan_out + 5'h01;
          sel_mask_out <= span(from_chan_out + 5'h01, from_chan_out + 5'h01);
        end else if (minus_in && from_chan_out != '0) begin
          from_chan_out <= from_chan_out - 5'h01;
          sel_mask_out <= span(from_chan_out - 5'h01, from_chan_out - 5'h01);
        end
      end else if (range_btn_in && !scatter_mode) begin
        // range opens at the next channel; a repress returns to single
        if (range_mode) begin
          range_mode <= 1'b0;
          sel_mask_out <= span(from_chan_out, from_chan_out);
        end else if (from_chan_out != crp_pkg::LAST_CH) begin
          range_mode <= 1'b1;
          to_chan_out <= from_chan_out + 5'h01;
          sel_mask_out <= span(from_chan_out, from_chan_out + 5'h01);
        end
      end else if (scatter_btn_in) begin
        scatter_mode <= !scatter_mode;
        if (scatter_mode) begin
          range_mode <= 1'b0;
          sel_mask_out <= span(from_chan_out, from_chan_out);
        end
      end else if (all_btn_in && scatter_mode && !armed) begin
        sel_mask_out <= '1;
      end
    end
  end

  // =========================================================
  // set / clear arming
  // =========================================================
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !panel_active_out) begin
      arm <= crp_pkg::ARM_NONE;
      arm_all <= 1'b0;
      arm_funcs <= '0;
    end else if (idle) begin
      if (set_btn_in || clear_btn_in) begin
        // a repress of the armed button disarms, applying first if flashing
        if ((set_btn_in && arm == crp_pkg::ARM_SET) || (clear_btn_in && arm == crp_pkg::ARM_CLR)) begin
          arm <= crp_pkg::ARM_NONE;
        end else begin
          arm <= set_btn_in ? crp_pkg::ARM_SET : crp_pkg::ARM_CLR;
        end
        arm_all <= 1'b0;
        arm_funcs <= '0;
      end else if (armed && func_press_in) begin
        arm_funcs[func_idx_in] <= 1'b1;
      end else if (armed && all_btn_in) begin
        arm_all <= 1'b1;
      end
    end
  end

  // =========================================================
  // undo window and flash timing
  // =========================================================
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !panel_active_out) begin
      undo_pend <= 1'b0;
      undo_cnt <= '0;
    end else if (idle && undo_btn_in) begin
      undo_pend <= !undo_pend;
      undo_cnt <= crp_pkg::CNT_W'(UNDO_CYC - 1);
    end else if (undo_pend) begin
      // a lone press times out with no effect
      if (undo_cnt == '0) begin
        undo_pend <= 1'b0;
      end else begin
        undo_cnt <= undo_cnt - 26'h000_0001;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flash_cnt <= '0;
      flash_ph <= 1'b0;
    end else if (flash_cnt == crp_pkg::CNT_W'(FLASH_CYC - 1)) begin
      flash_cnt <= '0;
      flash_ph <= !flash_ph;
    end else begin
      flash_cnt <= flash_cnt + 26'h000_0001;
    end
  end

  // =========================================================
  // registered indications
  // =========================================================
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      from_shown_out <= 1'b0;
      to_shown_out <= 1'b0;
      scatter_lamp_out <= 1'b0;
      set_lamp_out <= 1'b0;
      clear_lamp_out <= 1'b0;
      mf_chan_out <= '0;
      mf_valid_out <= 1'b0;
    end else begin
      busy_out <= !idle;
      // right window blank unless a range is open
      from_shown_out <= panel_active_out;
      to_shown_out <= panel_active_out && range_mode;
      scatter_lamp_out <= scatter_mode && flash_ph;
      // armed lamp flashes once all is pressed
      set_lamp_out <= (arm == crp_pkg::ARM_SET) && (!arm_all || flash_ph);
      clear_lamp_out <= (arm == crp_pkg::ARM_CLR) && (!arm_all || flash_ph);
      // master fader takes the from channel only
      mf_chan_out <= from_chan_out;
      mf_valid_out <= panel_active_out && master_fader_channel_assign_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    logic [crp_pkg::CH_W-1:0] bus;
    bus = first_set(lead_word[crp_pkg::NUM_TRK-1:0]);
    if (rst_in) begin
      mute_out <= '0;
      auto_solo_out <= '0;
      fx_to_track_out <= '0;
      pan_base_out <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        // exempt channels are never muted by solo
        mute_out[i] <= (|solo_req_in) && !solo_req_in[i] && !chan_state_out[i*W + crp_pkg::FN_SOLO_EX];
        auto_solo_out[i] <= (|solo_req_in) && after_fader_listen_in && exempt_afl_solo_opt_in &&
                            chan_state_out[i*W + crp_pkg::FN_SOLO_EX];
        // effects send takes over the track feed
        fx_to_track_out[i] <= effects_send_to_tracks_in && chan_state_out[i*W + crp_pkg::FN_FX_ON];
      end
      // pair or six-bus group base for the lead channel
      if (!(pan_to_track_busses_in || effects_send_to_tracks_in)) begin
        pan_base_out <= '0;
      end else if (surround_pan_in && !effects_send_to_tracks_in) begin
        pan_base_out <= crp_pkg::CH_W'((bus / crp_pkg::SURR_GROUP) * crp_pkg::SURR_GROUP);
      end else begin
        pan_base_out <= bus & crp_pkg::STEREO_MASK;
      end
    end
  end
endmodule : crp_routing_panel
`default_nettype wire

// ---- hw/crp_snap_mem.sv ----
// snapshot store for per-channel state words, one write and one read port
// a read of the word written in the same cycle returns its old value, as during a snapshot sweep
`timescale 1ns/10ps
`default_nettype none
module crp_snap_mem #(
  parameter int W = 32,
  parameter int D = 24,
  parameter int AW = 5
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [W-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [W-1:0] rd_data_out
);
  logic [W-1:0] mem [D];

  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // read data always registered, one cycle after the address
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule : crp_snap_mem
`default_nettype wire
